// >>> design/drive_cmd_params.svh
// Purpose: bit positions and reset values for the command and status words
// Assumes: 16-bit words, bit 0 is the least significant bit
// Notes: included by the decoder, status and top-level design files of the drive command block
//
// Summary of operation
// R1 - bit4 low forces ramp output to zero
// R2 - bit5 high accelerates, low freezes ramp output
// R3 - bit6 low forces ramp input to zero
// R4 - bit6 counts only when fieldbus is source
// R5 - rising bit7 clears fault to switch-on inhibited
// R6 - bit10 low ignores word except stop bits
// R7 - bit11 selects location b, if configured
// R8 - status bits 0-2 report readiness states
// R9 - status bit8 flags actual within tolerance
// R10 - status bit9 flags external control location
// R11 - status bit10 mirrors drive status bit10
// R12 - status bits 11-14 carry selectable signals
// R13 - start inhibit clears status bit 2
// R14 - status 3-7 fault/stops/inhibit/warning; reserved bits zero
// R15 - bit0 high readies; low ramps to stop
// R16 - bit1 low coasts, bit2 low emergency stops
// R17 - bit3 high runs if permissive, else inhibits
`ifndef DRIVE_CMD_PARAMS_SVH
`define DRIVE_CMD_PARAMS_SVH

// ----------------------------------------------------------------------
// command word bit positions
// ----------------------------------------------------------------------
`define CMD_RAMP_STOP_N 0
`define CMD_COAST_STOP_N 1
`define CMD_ESTOP_N 2
`define CMD_RUN 3
`define CMD_RAMP_OUT_EN 4
`define CMD_RAMP_HOLD_N 5
`define CMD_RAMP_IN_EN 6
`define CMD_RESET 7
`define CMD_REMOTE 10
`define CMD_LOC_B 11
`define CMD_STOP_MASK 16'h0007

// ----------------------------------------------------------------------
// status word bit positions and reset values
// ----------------------------------------------------------------------
`define ST_READY_ON 0
`define ST_READY_OP 1
`define ST_OP_EN 2
`define ST_FAULT 3
`define ST_COAST_OFF 4
`define ST_ESTOP_OFF 5
`define ST_INHIBITED 6
`define ST_WARNING 7
`define ST_ON_TARGET 8
`define ST_REMOTE 9
`define ST_ABOVE_LIMIT 10
`define ST_USER0 11
`define ST_ABOVE_LIMIT_SRC 10
`define CMD_RESET_VALUE 16'h0000
`define STATUS_RESET_VALUE 16'h0000

`endif

// >>> design/drive_cmd_pkg.sv
// Purpose: shared types of the drive command block
// Assumes: nothing beyond the params header
// Notes: sequencer state codes are written out
`default_nettype none
package drive_cmd_pkg;
	typedef logic [15:0] word_t;
	typedef enum logic [3:0] {
		st_not_ready = 4'h0,
		st_inhibited = 4'h1,
		st_ready_on = 4'h2,
		st_ready_op = 4'h3,
		st_op_enabled = 4'h4,
		st_out_enabled = 4'h5,
		st_accel_enabled = 4'h6,
		st_operating = 4'h7,
		st_ramp_stop = 4'h8,
		st_coast_stop = 4'h9,
		st_estop = 4'ha,
		st_fault = 4'hb
	} seq_state_e;
endpackage : drive_cmd_pkg
`default_nettype wire

// >>> design/cmd_fields_if.sv
// Purpose: decoded command fields from the decoder to the sequencer
// Assumes: one clock domain
// Notes: active-low stop bits keep their polarity
`default_nettype none
interface cmd_fields_if;
	logic ramp_stop_n;
	logic coast_stop_n;
	logic estop_n;
	logic run;
	logic ramp_out_en;
	logic ramp_hold_n;
	logic ramp_in_en;
	logic reset_pulse;
	logic loc_b;
	logic remote;
	modport decoder (output ramp_stop_n, coast_stop_n, estop_n, run, ramp_out_en,
		ramp_hold_n, ramp_in_en, reset_pulse, loc_b, remote);
	modport core (input ramp_stop_n, coast_stop_n, estop_n, run, ramp_out_en,
		ramp_hold_n, ramp_in_en, reset_pulse, loc_b, remote);
endinterface : cmd_fields_if
`default_nettype wire

// >>> design/cmd_decode.sv
// Purpose: accept the host command word and split it into fields
// Assumes: word is sampled every enabled cycle
// Notes: fields lag the word by one cycle
`include "drive_cmd_params.svh"
`default_nettype none
module cmd_decode
	import drive_cmd_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic clk_en,
	// command word and source selection
	input wire word_t host_command_word,
	input wire logic cfg_ramp_in_src_fb,
	input wire logic cfg_reset_src_fb,
	// decoded fields
	cmd_fields_if.decoder f
);
	word_t held;
	logic reset_last;
	word_t next_held;

	// with remote low only the stop bits get through; the rest keep their last value
	always_comb begin
		if (host_command_word[`CMD_REMOTE])
			next_held = host_command_word; // R6
		else
			next_held = (held & ~`CMD_STOP_MASK) | (host_command_word & `CMD_STOP_MASK); // R6
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			held <= `CMD_RESET_VALUE;
			reset_last <= 1'b0;
		end else if (clk_en) begin
			held <= next_held;
			// one cycle behind held, so the rising edge shows as a one-cycle pulse
			reset_last <= held[`CMD_RESET];
		end
	end

	// field split; the reset edge is a single enabled cycle
	assign f.ramp_stop_n = held[`CMD_RAMP_STOP_N];
	assign f.coast_stop_n = held[`CMD_COAST_STOP_N];
	assign f.estop_n = held[`CMD_ESTOP_N];
	assign f.run = held[`CMD_RUN];
	assign f.ramp_out_en = held[`CMD_RAMP_OUT_EN];
	assign f.ramp_hold_n = held[`CMD_RAMP_HOLD_N];
	assign f.ramp_in_en = held[`CMD_RAMP_IN_EN] | ~cfg_ramp_in_src_fb; // R4
	assign f.reset_pulse = cfg_reset_src_fb & held[`CMD_RESET] & ~reset_last & clk_en; // R5
	assign f.loc_b = held[`CMD_LOC_B];
	assign f.remote = held[`CMD_REMOTE];
endmodule : cmd_decode
`default_nettype wire

// >>> design/status_assemble.sv
// Purpose: build the registered status word for the host
// Assumes: state flags are already decoded by the sequencer
// Notes: bit 15 always reads zero
`include "drive_cmd_params.svh"
`default_nettype none
module status_assemble
	import drive_cmd_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic clk_en,
	// state flags
	input wire logic ready_on,
	input wire logic ready_op,
	input wire logic op_enabled,
	input wire logic fault,
	input wire logic coast_off,
	input wire logic estop_off,
	input wire logic inhibited,
	input wire logic warning,
	input wire logic on_target_flag,
	input wire logic remote,
	input wire word_t drive_status_word2,
	input wire logic [3:0] user_bits,
	// status word
	output word_t drive_state_word
);
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn)
			drive_state_word <= `STATUS_RESET_VALUE;
		else if (clk_en) begin
			drive_state_word <= `STATUS_RESET_VALUE; // R14
			drive_state_word[`ST_READY_ON] <= ready_on; // R8
			drive_state_word[`ST_READY_OP] <= ready_op; // R8
			drive_state_word[`ST_OP_EN] <= op_enabled; // R8
			drive_state_word[`ST_FAULT] <= fault; // R14
			drive_state_word[`ST_COAST_OFF] <= coast_off; // R14
			drive_state_word[`ST_ESTOP_OFF] <= estop_off; // R14
			drive_state_word[`ST_INHIBITED] <= inhibited; // R14
			drive_state_word[`ST_WARNING] <= warning; // R14
			drive_state_word[`ST_ON_TARGET] <= on_target_flag; // R9
			drive_state_word[`ST_REMOTE] <= remote; // R10
			drive_state_word[`ST_ABOVE_LIMIT] <= drive_status_word2[`ST_ABOVE_LIMIT_SRC]; // R11
			drive_state_word[`ST_USER0 +: 4] <= user_bits; // R12
		end
	end
endmodule : status_assemble
`default_nettype wire

// >>> design/drive_command_status_word.sv
// Purpose: fieldbus command interpreter and status word builder for a drive
// Assumes: command word arrives synchronous to ref_clk, refreshed cyclically
// Notes: the ramp generator and motor control sit outside and obey the outputs
`include "drive_cmd_params.svh"
`default_nettype none
module drive_command_status_word
	import drive_cmd_pkg::*;
(
	// clock, reset, enable
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic clk_en,
	// host words
	input wire word_t host_command_word,
	output word_t drive_state_word,
	// configuration
	input wire logic cfg_ramp_in_src_fb,
	input wire logic cfg_reset_src_fb,
	input wire logic cfg_loc_src_fb,
	input wire logic cfg_loc_b_default,
	input wire logic [3:0] cfg_user_sel [4],
	input wire word_t tolerance,
	// drive conditions
	input wire logic local_mode,
	input wire logic fault_active,
	input wire logic warning_active,
	input wire logic run_permissive,
	input wire word_t start_inhibit_word,
	input wire word_t drive_status_word2,
	input wire logic zero_speed,
	input wire word_t reference,
	input wire word_t actual_value,
	input wire word_t user_signals,
	// sequencer requests
	output logic modulator_enable,
	output logic ramp_out_force_zero,
	output logic ramp_hold,
	output logic ramp_in_force_zero,
	output logic ramp_stop_request,
	output logic coast_stop_request,
	output logic emergency_stop_request,
	output logic fault_reset,
	output logic external_location_b,
	output logic main_state_word_valid
);
	// ------------------------------------------------------------------
	// command decoding
	// ------------------------------------------------------------------
	cmd_fields_if f ();

	cmd_decode u_decode (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.clk_en(clk_en),
		.host_command_word(host_command_word),
		.cfg_ramp_in_src_fb(cfg_ramp_in_src_fb),
		.cfg_reset_src_fb(cfg_reset_src_fb),
		.f(f)
	);

	// ------------------------------------------------------------------
	// helper functions
	// ------------------------------------------------------------------
	// states from operation-enabled upward that drive the motor
	function automatic logic is_running(input seq_state_e s);
		is_running = (s == st_op_enabled) || (s == st_out_enabled) ||
			(s == st_accel_enabled) || (s == st_operating);
	endfunction : is_running

	// magnitude of a signed difference, saturated to 16 bits
	function automatic word_t abs_diff(input word_t a, input word_t b);
		logic signed [16:0] d;
		d = 17'($signed(a)) - 17'($signed(b));
		if (d < 0)
			d = -d;
		abs_diff = d[16] ? 16'hffff : d[15:0];
	endfunction : abs_diff

	// ------------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------------
	seq_state_e state;
	seq_state_e next_state;
	logic start_inhibited;
	logic stops_clear;

	// any set start-inhibit bit blocks a start
	assign start_inhibited = |start_inhibit_word; // R13
	assign stops_clear = f.coast_stop_n & f.estop_n;

	// priority: fault, coast, emergency stop, ramp stop, then normal stepping
	always_comb begin
		next_state = state;
		if (fault_active && state != st_fault)
			next_state = st_fault;
		else if (state == st_fault) begin
			if (f.reset_pulse)
				next_state = st_inhibited; // R5
		end else if (state == st_not_ready)
			next_state = st_inhibited; // power-up passes through inhibited whatever the word
		else if (!f.coast_stop_n && state != st_inhibited && state != st_coast_stop)
			next_state = st_coast_stop; // R16
		else if (!f.estop_n && state != st_inhibited && state != st_coast_stop &&
			state != st_estop)
			next_state = st_estop; // R16
		else begin
			case (state)
				st_not_ready: begin
					next_state = st_inhibited;
				end
				st_inhibited: begin
					// leaving needs bit 0 low and both the coast stop and emergency stop bits high
					if (stops_clear && !f.ramp_stop_n)
						next_state = st_ready_on;
				end
				st_ready_on: begin
					if (f.ramp_stop_n)
						next_state = st_ready_op; // R15
				end
				st_ready_op: begin
					if (!f.ramp_stop_n)
						next_state = st_ready_on; // R15
					else if (f.run && run_permissive && !start_inhibited)
						next_state = st_op_enabled; // R17
				end
				st_op_enabled, st_out_enabled, st_accel_enabled, st_operating: begin
					if (!f.ramp_stop_n)
						next_state = st_ramp_stop; // R15
					else if (!f.run || !run_permissive)
						next_state = st_ready_op; // R17
					else if (!f.ramp_out_en)
						next_state = st_op_enabled; // R1
					else if (!f.ramp_hold_n)
						next_state = st_out_enabled; // R2
					else if (!f.ramp_in_en)
						next_state = st_accel_enabled; // R3
					else
						next_state = st_operating; // R3
				end
				st_ramp_stop: begin
					if (f.ramp_stop_n && f.run && state == st_ramp_stop && !zero_speed)
						next_state = st_ramp_stop;
					else if (zero_speed)
						next_state = st_ready_on; // R15
				end
				st_coast_stop, st_estop: begin
					// both end up inhibited once the shaft has stopped
					if (zero_speed)
						next_state = st_inhibited; // R16
				end
				default: begin
					next_state = st_not_ready;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn)
			state <= st_not_ready;
		else if (clk_en)
			state <= next_state;
	end

	// ------------------------------------------------------------------
	// requests to the ramp generator and motor control
	// ------------------------------------------------------------------
	// registered from next_state so the drive sees clean levels; they change in the same cycle as the state
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			modulator_enable <= 1'b0;
			ramp_out_force_zero <= 1'b1;
			ramp_hold <= 1'b1;
			ramp_in_force_zero <= 1'b1;
			ramp_stop_request <= 1'b0;
			coast_stop_request <= 1'b0;
			emergency_stop_request <= 1'b0;
		end else if (clk_en) begin
			// coast stop drops the modulator at once, other stops keep it running
			modulator_enable <= is_running(next_state) || next_state == st_ramp_stop ||
				next_state == st_estop; // R16
			ramp_out_force_zero <= !(next_state == st_out_enabled ||
				next_state == st_accel_enabled || next_state == st_operating); // R1
			ramp_hold <= !(next_state == st_accel_enabled ||
				next_state == st_operating); // R2
			ramp_in_force_zero <= next_state != st_operating; // R3
			ramp_stop_request <= next_state == st_ramp_stop; // R15
			coast_stop_request <= next_state == st_coast_stop; // R16
			emergency_stop_request <= next_state == st_estop; // R16
		end
	end

	// fault reset pulse lasts one enabled cycle and only leaves the fault state
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn)
			fault_reset <= 1'b0;
		else if (clk_en)
			fault_reset <= state == st_fault && f.reset_pulse; // R5
	end

	// ------------------------------------------------------------------
	// control location
	// ------------------------------------------------------------------
	// the fieldbus only picks the location when configured to; else the configured default cfg_loc_b_default
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn)
			external_location_b <= 1'b0;
		else if (clk_en)
			external_location_b <= cfg_loc_src_fb ? f.loc_b : cfg_loc_b_default; // R7
	end

	// ------------------------------------------------------------------
	// on-target compare and user bits
	// ------------------------------------------------------------------
	logic on_target_flag;
	logic [3:0] user_bits;

	// within the window only counts while operating
	assign on_target_flag = state == st_operating &&
		abs_diff(actual_value, reference) <= tolerance; // R9

	// each user bit picks one of sixteen internal signals
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_user
			assign user_bits[gi] = user_signals[cfg_user_sel[gi]]; // R12
		end
	endgenerate

	// ------------------------------------------------------------------
	// status word
	// ------------------------------------------------------------------
	logic ready_on;
	logic ready_op;
	logic op_enabled;

	assign ready_on = state == st_ready_on || state == st_ready_op ||
		is_running(state) || state == st_ramp_stop; // R8
	assign ready_op = state == st_ready_op || is_running(state); // R8
	assign op_enabled = is_running(state) && !start_inhibited; // R13

	status_assemble u_status (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.clk_en(clk_en),
		.ready_on(ready_on),
		.ready_op(ready_op),
		.op_enabled(op_enabled),
		.fault(state == st_fault),
		.coast_off(state != st_coast_stop && f.coast_stop_n),
		.estop_off(state != st_estop && f.estop_n),
		.inhibited(state == st_inhibited),
		.warning(warning_active),
		.on_target_flag(on_target_flag),
		.remote(!local_mode),
		.drive_status_word2(drive_status_word2),
		.user_bits(user_bits),
		.drive_state_word(drive_state_word)
	);

	// status word valid once the sequencer has left its power-up state
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn)
			main_state_word_valid <= 1'b0;
		else if (clk_en)
			main_state_word_valid <= state != st_not_ready;
	end
endmodule : drive_command_status_word
`default_nettype wire

// >>> tb/drive_command_status_word_monitor.sv
// Purpose: concurrent checks on the drive command interpreter ports
// Assumes: clk_en high; status settles within five enabled edges of its cause
// Notes: bound to the top module below
`default_nettype none
module drive_cmd_monitor
	import drive_cmd_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic clk_en,
	// host words and configuration
	input wire word_t host_command_word,
	input wire word_t drive_state_word,
	input wire logic cfg_ramp_in_src_fb,
	input wire logic cfg_reset_src_fb,
	input wire logic [3:0] cfg_user_sel [4],
	// drive conditions
	input wire logic local_mode,
	input wire logic warning_active,
	input wire word_t start_inhibit_word,
	input wire word_t drive_status_word2,
	input wire word_t user_signals,
	// requests
	input wire logic ramp_out_force_zero,
	input wire logic ramp_in_force_zero,
	input wire logic fault_reset
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	a_reserved_bit_zero: assert property (drive_state_word[15] == 1'b0)
		else $error("status bit 15 not zero");
	// five stable cycles cover capture, state and status registers
	a_remote_flag: assert property (
		(clk_en && $stable(local_mode))[*5] |-> drive_state_word[9] == !local_mode)
		else $error("remote flag wrong");
	a_above_limit_copy: assert property (
		(clk_en && $stable(drive_status_word2))[*5]
		|-> drive_state_word[10] == drive_status_word2[10])
		else $error("above limit flag wrong");
	a_warning_copy: assert property (
		(clk_en && $stable(warning_active))[*5] |-> drive_state_word[7] == warning_active)
		else $error("warning flag wrong");
	a_user_bit_zero: assert property (
		(clk_en && $stable(user_signals[cfg_user_sel[0]]))[*5]
		|-> drive_state_word[11] == user_signals[cfg_user_sel[0]])
		else $error("user bit 0 wrong");
	a_inhibit_clears_run: assert property (
		(clk_en && start_inhibit_word != 16'h0000)[*5] |-> !drive_state_word[2])
		else $error("operation enabled despite start inhibit");
	a_ramp_out_zero: assert property (
		(clk_en && host_command_word[10] && !host_command_word[4])[*5] |-> ramp_out_force_zero)
		else $error("ramp output not forced to zero");
	a_ramp_in_zero: assert property (
		(clk_en && cfg_ramp_in_src_fb && host_command_word[10] && !host_command_word[6])[*5]
		|-> ramp_in_force_zero)
		else $error("ramp input not forced to zero");
	a_coast_status: assert property (
		(clk_en && !host_command_word[1])[*5] |-> !drive_state_word[4])
		else $error("coast stop not reported");
	a_reset_pulse_one: assert property (fault_reset && clk_en |=> !fault_reset)
		else $error("fault reset longer than one cycle");
	a_reset_needs_source: assert property ($rose(fault_reset) |-> cfg_reset_src_fb)
		else $error("fault reset while bus is not reset source");

	c_fault_reset: cover property (fault_reset);
	c_on_target: cover property (drive_state_word[8]);
	c_coast: cover property (!host_command_word[1] ##5 !drive_state_word[4]);
endmodule : drive_cmd_monitor

bind drive_command_status_word drive_cmd_monitor u_drive_cmd_monitor (
	.ref_clk, .resetn, .clk_en, .host_command_word, .drive_state_word,
	.cfg_ramp_in_src_fb, .cfg_reset_src_fb, .cfg_user_sel, .local_mode,
	.warning_active, .start_inhibit_word, .drive_status_word2, .user_signals,
	.ramp_out_force_zero, .ramp_in_force_zero, .fault_reset
);
`default_nettype wire

// >>> tb/host_master_model.sv
// Purpose: cyclic bus master that refreshes the command word
// Assumes: one word per cycle, no framing
// Notes: the word changes only on the falling edge, away from sampling
`default_nettype none
module host_master_model
	import drive_cmd_pkg::*;
(
	// clock
	input wire logic ref_clk,
	// word the master wants to send
	input wire word_t word_req,
	// word as seen by the drive
	output var word_t host_command_word
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------------------------------
	// cyclic refresh
	// ----------------------------------------------------------------
	initial host_command_word = 16'h0000;
	// reserved bits 8 and 9 always go out as zero so the drive never sees junk there
	always @(negedge ref_clk) begin
		host_command_word <= word_req & 16'hfcff;
	end
endmodule : host_master_model
`default_nettype wire

// >>> tb/drive_command_status_word_bench.sv
// Purpose: directed scenarios for the drive command interpreter
// Assumes: sixteen cycles let any command walk settle
// Notes: inputs change at the falling edge only
`default_nettype none
module drive_command_status_word_bench
	import drive_cmd_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------------------------------
	// signals and instances
	// ----------------------------------------------------------------
	logic ref_clk = 1'b0;
	logic resetn = 1'b0;
	logic clk_en = 1'b1;
	word_t word_req = 16'h0006;
	word_t host_command_word, drive_state_word;
	logic cfg_ramp_in_src_fb = 1'b1, cfg_reset_src_fb = 1'b0, cfg_loc_src_fb = 1'b1;
	logic cfg_loc_b_default = 1'b0, local_mode = 1'b0, fault_active = 1'b0;
	logic warning_active = 1'b0, run_permissive = 1'b1, zero_speed = 1'b0;
	logic [3:0] cfg_user_sel [4] = '{4'h3, 4'h5, 4'h7, 4'h9};
	word_t tolerance = 16'h0010, start_inhibit_word = 16'h0000;
	word_t drive_status_word2 = 16'h0400, reference = 16'h0100;
	word_t actual_value = 16'h0100, user_signals = 16'h0088;
	logic modulator_enable, ramp_out_force_zero, ramp_hold, ramp_in_force_zero;
	logic ramp_stop_request, coast_stop_request, emergency_stop_request;
	logic fault_reset, external_location_b, main_state_word_valid;
	int n_fail = 0, n_tests = 0, cycles = 0, n_pulse = 0;

	host_master_model u_host_master_model (.ref_clk, .word_req, .host_command_word);
	drive_command_status_word u_drive_command_status_word (
		.ref_clk, .resetn, .clk_en, .host_command_word, .drive_state_word,
		.cfg_ramp_in_src_fb, .cfg_reset_src_fb, .cfg_loc_src_fb, .cfg_loc_b_default,
		.cfg_user_sel, .tolerance, .local_mode, .fault_active, .warning_active,
		.run_permissive, .start_inhibit_word, .drive_status_word2, .zero_speed,
		.reference, .actual_value, .user_signals, .modulator_enable,
		.ramp_out_force_zero, .ramp_hold, .ramp_in_force_zero, .ramp_stop_request,
		.coast_stop_request, .emergency_stop_request, .fault_reset,
		.external_location_b, .main_state_word_valid
	);

	// clock and a hang guard well above the ~530 cycles the tests need
	always #5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 5000) begin
			n_fail++;
			close_out();
		end
	end

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic chk(input string name, input word_t exp, input word_t got);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected %s: expected %h seen %h", name, exp, got);
		end
	endtask : chk

	// hand a word to the master, let it settle and count reset pulses meanwhile
	task automatic send(input word_t w);
		word_req = w;
		repeat (16) begin
			@(negedge ref_clk);
			if (fault_reset === 1'b1)
				n_pulse++;
		end
	endtask : send

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : close_out

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		chk("state_word", 16'h0000, drive_state_word);
		chk("force_flags", 16'h0007, {13'h0, ramp_out_force_zero, ramp_hold, ramp_in_force_zero});
		$display("t_reset done");
	endtask : t_reset

	task automatic t_status();
		send(16'h0006);
		chk("state_word", 16'h2e31, drive_state_word);
		chk("valid", 16'h0001, {15'h0, main_state_word_valid});
		warning_active = 1'b1;
		local_mode = 1'b1;
		user_signals = 16'h0220;
		send(16'h0006);
		chk("state_word", 16'h54b1, drive_state_word);
		warning_active = 1'b0;
		local_mode = 1'b0;
		user_signals = 16'h0088;
		$display("t_status done");
	endtask : t_status

	task automatic t_run();
		run_permissive = 1'b0;
		send(16'h047f);
		chk("op_enabled", 16'h0000, drive_state_word & 16'h0004);
		run_permissive = 1'b1;
		start_inhibit_word = 16'h0001;
		send(16'h047f);
		chk("op_enabled", 16'h0000, drive_state_word & 16'h0004);
		start_inhibit_word = 16'h0000;
		send(16'h047f);
		chk("state_word", 16'h2f37, drive_state_word);
		chk("ramp_flags", 16'h0008, {12'h0, modulator_enable, ramp_out_force_zero,
			ramp_hold, ramp_in_force_zero});
		actual_value = 16'h0111; // one past the window
		send(16'h047f);
		chk("on_target", 16'h0000, drive_state_word & 16'h0100);
		actual_value = 16'h0110; // right on the window edge
		send(16'h047f);
		chk("on_target", 16'h0100, drive_state_word & 16'h0100);
		$display("t_run done");
	endtask : t_run

	task automatic t_ramp();
		logic [2:0] flags;
		for (int k = 0; k < 3; k++) begin
			send(16'h047f & ~(16'h0010 << k));
			flags = {ramp_out_force_zero, ramp_hold, ramp_in_force_zero};
			chk("ramp_flag", 16'h0001, {15'h0, flags[2-k]});
			send(16'h047f);
		end
		cfg_ramp_in_src_fb = 1'b0;
		send(16'h043f);
		chk("ramp_in_zero", 16'h0000, {15'h0, ramp_in_force_zero});
		cfg_ramp_in_src_fb = 1'b1;
		send(16'h047f);
		$display("t_ramp done");
	endtask : t_ramp

	task automatic t_remote();
		send(16'h005f);
		chk("ramp_hold", 16'h0000, {15'h0, ramp_hold});
		send(16'h005e);
		chk("ramp_stop", 16'h0001, {15'h0, ramp_stop_request});
		zero_speed = 1'b1;
		send(16'h005e);
		chk("ready_bits", 16'h0001, drive_state_word & 16'h0007);
		zero_speed = 1'b0;
		$display("t_remote done");
	endtask : t_remote

	task automatic t_loc();
		send(16'h0c06);
		chk("loc_b", 16'h0001, {15'h0, external_location_b});
		send(16'h0406);
		chk("loc_b", 16'h0000, {15'h0, external_location_b});
		cfg_loc_src_fb = 1'b0;
		cfg_loc_b_default = 1'b1;
		send(16'h0406);
		chk("loc_b", 16'h0001, {15'h0, external_location_b});
		cfg_loc_src_fb = 1'b1;
		cfg_loc_b_default = 1'b0;
		$display("t_loc done");
	endtask : t_loc

	// k=0 coast stop, k=1 emergency stop, each from operating
	task automatic t_stop();
		for (int k = 0; k < 2; k++) begin
			send(16'h0406);
			send(16'h047f);
			send(16'h047f ^ (16'h0002 << k));
			chk("stop_req", 16'h0002 >> k, {14'h0, coast_stop_request,
				emergency_stop_request});
			chk("stop_bits", 16'h0020 >> k, drive_state_word & 16'h0030);
			zero_speed = 1'b1;
			send(16'h047f ^ (16'h0002 << k));
			chk("inhibited", 16'h0040, drive_state_word & 16'h0040);
			zero_speed = 1'b0;
		end
		$display("t_stop done");
	endtask : t_stop

	task automatic t_fault();
		fault_active = 1'b1;
		send(16'h0406);
		chk("fault_bit", 16'h0008, drive_state_word & 16'h0008);
		fault_active = 1'b0;
		n_pulse = 0;
		send(16'h04c6);
		send(16'h0406);
		chk("reset_pulses", 16'h0000, word_t'(n_pulse));
		chk("inhibited", 16'h0000, drive_state_word & 16'h0040);
		cfg_reset_src_fb = 1'b1;
		// bit 0 high keeps the drive parked in switch-on inhibited after the reset
		send(16'h04c7);
		chk("reset_pulses", 16'h0001, word_t'(n_pulse));
		chk("inhibited", 16'h0040, drive_state_word & 16'h0040);
		$display("t_fault done");
	endtask : t_fault

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (2) @(negedge ref_clk);
		t_reset();
		repeat (3) @(negedge ref_clk);
		resetn = 1'b1;
		t_status();
		t_run();
		t_ramp();
		t_remote();
		t_loc();
		t_stop();
		t_fault();
		close_out();
	end
endmodule : drive_command_status_word_bench
`default_nettype wire
